// [inc/tcs_cfg_if.sv]
`timescale 1ns/100ps
interface tcs_cfg_if;
   logic rate_mode_select;
   logic [1:0] input_rate_field;
   logic [1:0] output_rate_field;
   logic [1:0] switch_config_field;
   logic mux_bus;
   logic [3:0] pair_a;
   logic [3:0] pair_b;
   logic [15:0] in_enable;
   logic [9:0] out_enable;
   logic [7:0] channels;
   logic nibble;
   logic blocking;
   logic const_delay_ok;
   logic fast_clock;
   logic offset_ok;
   logic cfg_error;
   modport decoder (
      input rate_mode_select, input_rate_field, output_rate_field, switch_config_field,
      input mux_bus, pair_a, pair_b,
      output in_enable, out_enable, channels, nibble, blocking, const_delay_ok,
      output fast_clock, offset_ok, cfg_error
   );
   modport owner (
      output rate_mode_select, input_rate_field, output_rate_field, switch_config_field,
      output mux_bus, pair_a, pair_b,
      input in_enable, out_enable, channels, nibble, blocking, const_delay_ok,
      input fast_clock, offset_ok, cfg_error
   );
endinterface

// [inc/tcs_pkg.sv]
package tcs_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] PAIR_OFS = 8'h04;
   localparam logic [7:0] OFFSET_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   // ----------------------------------------
   // mode register fields, reset values and offset fields
   // ----------------------------------------
   localparam int RATE_MODE_BIT = 0;
   localparam int IN_RATE_LSB = 1;
   localparam int OUT_RATE_LSB = 3;
   localparam int SW_CFG_LSB = 5;
   localparam int MUX_BUS_BIT = 7;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] PAIR_RESET = 8'h00;
   localparam logic [3:0] OFFSET_RESET = 4'h0;
   localparam int OFFSET_EN_BIT = 3;
   localparam logic [2:0] OFFSET_MAX = 3'h4;
   // ----------------------------------------
   // encodings
   // ----------------------------------------
   typedef enum logic [1:0] {
      RATE_2M = 2'b00,
      RATE_4M = 2'b01,
      RATE_8M = 2'b10
   } tcs_rate_t;
   typedef enum logic [1:0] {
      CFG_8X8 = 2'b00,
      CFG_16X8 = 2'b01,
      CFG_PAIR = 2'b10,
      CFG_NIBBLE = 2'b11
   } tcs_cfg_t;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
   localparam int FRAME_SYNC_STAGES = 3;
endpackage

// [rtl/tcs_decode.sv]
`timescale 1ns/100ps
// combinational decode of the operating arrangement
module tcs_decode (
   tcs_cfg_if.decoder cfg
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] low_mask(input logic [4:0] n);
      low_mask = 16'hffff >> (5'd16 - n);
   endfunction

   function automatic logic [15:0] pair_bit(input logic [3:0] p);
      pair_bit = (p >= 4'h2 && p <= 4'h9) ? (16'h0001 << p) : 16'h0000;
   endfunction

   // ----------------------------------------
   // arrangement decode
   // ----------------------------------------
   always_comb begin
      logic [4:0] ni;
      logic [4:0] no;
      logic [15:0] out_mask;
      ni = 5'd0;
      no = 5'd0;
      out_mask = 16'h0000;
      cfg.channels = 8'd32;
      cfg.nibble = 1'b0;
      cfg.blocking = 1'b0;
      cfg.const_delay_ok = 1'b1;
      cfg.fast_clock = 1'b0;
      cfg.cfg_error = 1'b0;
      cfg.in_enable = 16'h0000;
      cfg.out_enable = 10'h000;
      if (!cfg.rate_mode_select) begin
         case (cfg.input_rate_field)
            tcs_pkg::RATE_2M: begin
               case (cfg.switch_config_field)
                  tcs_pkg::CFG_8X8: begin
                     ni = 5'd8;
                     no = 5'd8;
                  end
                  tcs_pkg::CFG_16X8: begin
                     ni = 5'd16;
                     no = 5'd8;
                     cfg.blocking = 1'b1;
                     cfg.const_delay_ok = 1'b0;
                     cfg.cfg_error = !cfg.mux_bus;
                     if (!cfg.mux_bus) begin
                        ni = 5'd0;
                        no = 5'd0;
                     end
                  end
                  tcs_pkg::CFG_PAIR: begin
                     // fixed pairs plus a and b; delay choice kept
                     ni = 5'd2;
                     no = 5'd2;
                     cfg.in_enable = pair_bit(cfg.pair_a) | pair_bit(cfg.pair_b);
                     cfg.out_enable = cfg.in_enable[9:0];
                     cfg.cfg_error = (pair_bit(cfg.pair_a) == 16'h0000) ||
                                     (pair_bit(cfg.pair_b) == 16'h0000) ||
                                     (cfg.pair_a == cfg.pair_b);
                  end
                  default: begin
                     // 64 nibbles; eight in four out
                     ni = 5'd8;
                     no = 5'd4;
                     cfg.channels = 8'd64;
                     cfg.nibble = 1'b1;
                     cfg.blocking = 1'b1;
                     cfg.const_delay_ok = 1'b0;
                  end
               endcase
            end
            tcs_pkg::RATE_4M: begin
               cfg.channels = 8'd64;
               if (cfg.switch_config_field == tcs_pkg::CFG_8X8) begin
                  ni = 5'd8;
                  no = 5'd4;
                  cfg.blocking = 1'b1;
                  cfg.const_delay_ok = 1'b0;
               end else begin
                  ni = 5'd4;
                  no = 5'd4;
               end
            end
            tcs_pkg::RATE_8M: begin
               ni = 5'd2;
               no = 5'd2;
               cfg.channels = 8'd128;
               cfg.fast_clock = 1'b1;
            end
            default: begin
               cfg.cfg_error = 1'b1;
            end
         endcase
      end else begin
         // two rate fields; non-blocking; stream counts
         case ({cfg.input_rate_field, cfg.output_rate_field})
            {tcs_pkg::RATE_2M, tcs_pkg::RATE_4M}: begin
               ni = 5'd8;
               no = 5'd4;
            end
            {tcs_pkg::RATE_2M, tcs_pkg::RATE_8M}: begin
               ni = 5'd8;
               no = 5'd2;
               cfg.fast_clock = 1'b1;
            end
            {tcs_pkg::RATE_4M, tcs_pkg::RATE_2M}: begin
               ni = 5'd4;
               no = 5'd8;
            end
            {tcs_pkg::RATE_8M, tcs_pkg::RATE_2M}: begin
               ni = 5'd2;
               no = 5'd8;
               cfg.fast_clock = 1'b1;
            end
            default: begin
               cfg.cfg_error = 1'b1;
            end
         endcase
         cfg.channels = 8'd0;
      end
      cfg.in_enable = cfg.in_enable | low_mask(ni);
      // only ten output streams exist, so the mask is cut to its low bits
      out_mask = low_mask(no);
      cfg.out_enable = cfg.out_enable | out_mask[9:0];
      cfg.offset_ok = (cfg.input_rate_field == tcs_pkg::RATE_4M) ||
                      (cfg.input_rate_field == tcs_pkg::RATE_8M);
   end
endmodule

// [rtl/tcs_switch_cfg.sv]
`timescale 1ns/100ps
module tcs_switch_cfg (
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic CE,
   // axi4-lite write address
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // axi4-lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // axi4-lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // serial link
   input wire logic FRAME_PULSE_IN,
   input wire logic [15:0] SERIAL_IN_LINES,
   output logic [15:0] SAMPLED_IN_LINES,
   output logic IN_FRAME,
   output logic OUT_FRAME,
   output logic [9:0] SERIAL_OUT_OE_N,
   // arrangement status
   output logic BLOCKING,
   output logic CONST_DELAY_OK,
   output logic NIBBLE_MODE,
   output logic FAST_CLOCK
);
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_meta;
   logic rst_n;
   // two stage release so the design leaves reset on a clean edge
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // registers and decode
   // ----------------------------------------
   logic [7:0] mode;
   logic [7:0] pair_select_reg;
   logic [3:0] input_offset_reg;
   logic [7:0] next_mode;
   logic [7:0] next_pair;
   logic [3:0] next_offset;
   tcs_cfg_if cfg ();

   assign cfg.rate_mode_select = mode[tcs_pkg::RATE_MODE_BIT];
   assign cfg.input_rate_field = mode[tcs_pkg::IN_RATE_LSB +: 2];
   assign cfg.output_rate_field = mode[tcs_pkg::OUT_RATE_LSB +: 2];
   assign cfg.switch_config_field = mode[tcs_pkg::SW_CFG_LSB +: 2];
   assign cfg.mux_bus = mode[tcs_pkg::MUX_BUS_BIT];
   assign cfg.pair_a = pair_select_reg[3:0];
   assign cfg.pair_b = pair_select_reg[7:4];

   tcs_decode u_decode (
      .cfg(cfg)
   );

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_held;
   logic next_w_held;
   logic [7:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   // write channel: address and data taken in either order, answer follows both
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = BVALID;
      next_bresp = BRESP;
      next_mode = mode;
      next_pair = pair_select_reg;
      next_offset = input_offset_reg;
      if (AWVALID && AWREADY) begin
         next_aw_held = 1'b1;
         next_aw_addr = AWADDR;
      end
      if (WVALID && WREADY) begin
         next_w_held = 1'b1;
         next_w_data = WDATA;
         next_w_strb = WSTRB;
      end
      if (BVALID && BREADY) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held && !BVALID) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = tcs_pkg::AXI_OKAY;
         case (aw_addr)
            tcs_pkg::MODE_OFS: begin
               if (w_strb[0]) begin
                  next_mode = w_data[7:0];
               end
            end
            tcs_pkg::PAIR_OFS: begin
               if (w_strb[0]) begin
                  next_pair = w_data[7:0];
               end
            end
            tcs_pkg::OFFSET_OFS: begin
               if (w_strb[0]) begin
                  next_offset = w_data[3:0];
               end
            end
            tcs_pkg::STATUS_OFS: begin
               next_bresp = tcs_pkg::AXI_SLVERR; // read only
            end
            default: begin
               next_bresp = tcs_pkg::AXI_SLVERR;
            end
         endcase
      end
      // one write in flight: ready only while that channel is empty
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
   end

   // read channel: answer one cycle after the address is taken
   always_comb begin
      next_arready = ARREADY;
      next_rvalid = RVALID;
      next_rdata = RDATA;
      next_rresp = RRESP;
      if (RVALID && RREADY) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      if (ARVALID && ARREADY) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = tcs_pkg::AXI_OKAY;
         case (ARADDR)
            tcs_pkg::MODE_OFS: next_rdata = {24'h000000, mode};
            tcs_pkg::PAIR_OFS: next_rdata = {24'h000000, pair_select_reg};
            tcs_pkg::OFFSET_OFS: next_rdata = {28'h0000000, input_offset_reg};
            tcs_pkg::STATUS_OFS: begin
               next_rdata = {cfg.channels, 2'b00, cfg.out_enable, 6'h00,
                             cfg.cfg_error, cfg.offset_ok, cfg.fast_clock,
                             cfg.nibble, cfg.const_delay_ok, cfg.blocking};
            end
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = tcs_pkg::AXI_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= 2'b00;
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= 2'b00;
         mode <= tcs_pkg::MODE_RESET;
         pair_select_reg <= tcs_pkg::PAIR_RESET;
         input_offset_reg <= tcs_pkg::OFFSET_RESET;
      end else if (CE) begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         AWREADY <= next_awready;
         WREADY <= next_wready;
         BVALID <= next_bvalid;
         BRESP <= next_bresp;
         ARREADY <= next_arready || (!RVALID && !ARREADY);
         RVALID <= next_rvalid;
         RDATA <= next_rdata;
         RRESP <= next_rresp;
         mode <= next_mode;
         pair_select_reg <= next_pair;
         input_offset_reg <= next_offset;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] fp_sync;
   logic [15:0] in_s1;
   logic [15:0] in_s2;
   logic [15:0] in_s3;
   logic fp_level;
   logic next_fp_level;
   logic [15:0] in_level;
   logic [15:0] next_in_level;

   // a change counts only once stages two and three agree
   always_comb begin
      next_fp_level = (fp_sync[1] == fp_sync[2]) ? fp_sync[2] : fp_level;
      for (int i = 0; i < 16; i++) begin
         next_in_level[i] = (in_s2[i] == in_s3[i]) ? in_s3[i] : in_level[i];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         fp_sync <= 3'b000;
         in_s1 <= 16'h0000;
         in_s2 <= 16'h0000;
         in_s3 <= 16'h0000;
         fp_level <= 1'b0;
         in_level <= 16'h0000;
      end else if (CE) begin
         fp_sync <= {fp_sync[1:0], FRAME_PULSE_IN};
         in_s1 <= SERIAL_IN_LINES;
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         fp_level <= next_fp_level;
         in_level <= next_in_level;
      end
   end

   // ----------------------------------------
   // frame timing and offset
   // ----------------------------------------
   logic fp_prev;
   logic [2:0] off_cnt;
   logic off_run;
   logic [2:0] next_off_cnt;
   logic next_off_run;
   logic next_in_frame;
   logic fp_edge;
   logic offset_active;
   logic [2:0] offset_amount;

   assign fp_edge = fp_level && !fp_prev;
   // offset honoured only at higher rates
   assign offset_active = input_offset_reg[tcs_pkg::OFFSET_EN_BIT] && cfg.offset_ok;
   // amounts above four are clamped rather than refused
   assign offset_amount = (input_offset_reg[2:0] > tcs_pkg::OFFSET_MAX) ?
                          tcs_pkg::OFFSET_MAX : input_offset_reg[2:0];

   // virtual input frame delayed by offset
   always_comb begin
      next_off_cnt = off_cnt;
      next_off_run = off_run;
      next_in_frame = 1'b0;
      if (fp_edge) begin
         if (!offset_active || offset_amount == 3'd0) begin
            next_in_frame = 1'b1;
            next_off_run = 1'b0;
         end else begin
            next_off_cnt = offset_amount - 3'd1;
            next_off_run = 1'b1;
         end
      end else if (off_run) begin
         if (off_cnt == 3'd0) begin
            next_in_frame = 1'b1;
            next_off_run = 1'b0;
         end else begin
            next_off_cnt = off_cnt - 3'd1;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         fp_prev <= 1'b0;
         off_cnt <= 3'd0;
         off_run <= 1'b0;
         IN_FRAME <= 1'b0;
         OUT_FRAME <= 1'b0;
      end else if (CE) begin
         fp_prev <= fp_level;
         off_cnt <= next_off_cnt;
         off_run <= next_off_run;
         IN_FRAME <= next_in_frame;
         OUT_FRAME <= fp_edge;
      end
   end

   // ----------------------------------------
   // stream gating and status outputs
   // ----------------------------------------
   // mask inputs, float unused outputs
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         SAMPLED_IN_LINES <= 16'h0000;
         SERIAL_OUT_OE_N <= 10'h3ff;
         BLOCKING <= 1'b0;
         CONST_DELAY_OK <= 1'b0;
         NIBBLE_MODE <= 1'b0;
         FAST_CLOCK <= 1'b0;
      end else if (CE) begin
         SAMPLED_IN_LINES <= cfg.cfg_error ? 16'h0000 : (in_level & cfg.in_enable);
         SERIAL_OUT_OE_N <= cfg.cfg_error ? 10'h3ff : ~cfg.out_enable;
         BLOCKING <= cfg.blocking;
         CONST_DELAY_OK <= cfg.const_delay_ok;
         NIBBLE_MODE <= cfg.nibble;
         FAST_CLOCK <= cfg.fast_clock;
      end
   end
endmodule

// [verification/tcs_backplane_model.sv]
`timescale 1ns/100ps
// far-side backplane device: frame pulse source and serial line driver
module tcs_backplane_model (
   // clock
   input wire logic clk,
   // control
   input wire logic hold_high,
   // backplane pins
   output logic frame_pulse,
   output logic [15:0] lines
);
   logic [5:0] cnt = 6'h00;
   initial frame_pulse = 1'h0;
   initial lines = 16'h0000;
   // pulses 40 cycles apart, far above the minimum spacing
   // lines follow count bit 3, eight cycles per level but sixteen low across the wrap, so a stale level never passes for data
   always @(posedge clk) begin
      cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
      frame_pulse <= (cnt < 6'h02);
      lines <= hold_high ? 16'hffff : {16{cnt[3]}};
   end
endmodule

// [verification/tcs_switch_cfg_asserts.sv]
`timescale 1ns/100ps
// ----
// port checks of the switch configuration block
// ----
module tcs_switch_cfg_asserts (
   // clock and reset
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic CE,
   // register bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   // serial side
   input wire logic FRAME_PULSE_IN,
   input wire logic [15:0] SAMPLED_IN_LINES,
   input wire logic IN_FRAME,
   input wire logic OUT_FRAME,
   input wire logic [9:0] SERIAL_OUT_OE_N,
   // status
   input wire logic BLOCKING,
   input wire logic CONST_DELAY_OK,
   input wire logic NIBBLE_MODE,
   input wire logic FAST_CLOCK
);
   default clocking dc @(posedge CLOCK); endclocking
   // a frozen block answers nothing, so checks pause while the enable is low
   default disable iff (!ARST_N || !CE);
   frame_follow_a: assert property ($rose(FRAME_PULSE_IN) |-> ##[2:6] OUT_FRAME)
      else $error("no out frame after pulse");
   frame_pulse_a: assert property (OUT_FRAME |=> !OUT_FRAME)
      else $error("out frame too long");
   virt_frame_a: assert property (OUT_FRAME |-> ##[0:4] IN_FRAME)
      else $error("in frame late");
   nib_shape_a: assert property (NIBBLE_MODE |-> BLOCKING && !CONST_DELAY_OK
      && (&SERIAL_OUT_OE_N[9:4]))
      else $error("nibble shape wrong");
   blk_var_a: assert property (BLOCKING && !(&SERIAL_OUT_OE_N) |-> !CONST_DELAY_OK)
      else $error("blocking with constant delay");
   fast_pair_a: assert property (FAST_CLOCK [*3] |-> !BLOCKING && (&SERIAL_OUT_OE_N[9:8])
      && SAMPLED_IN_LINES[15:8] == 8'h00)
      else $error("fast mode streams wrong");
   // upper inputs only in sixteen by eight
   hi_inputs_a: assert property (SAMPLED_IN_LINES[15:10] != 6'h00 |->
      BLOCKING || $past(BLOCKING))
      else $error("upper input not masked");
   // write answer timing
   wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID)
      else $error("write answer timing");
   rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
      else $error("read answer timing");
   resp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   data_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   // main scenarios
   nib_c: cover property (NIBBLE_MODE);
   fast_c: cover property (FAST_CLOCK);
   offs_c: cover property (OUT_FRAME ##4 IN_FRAME);
endmodule
bind tcs_switch_cfg tcs_switch_cfg_asserts chk_u (.CLOCK(CLOCK), .ARST_N(ARST_N), .CE(CE),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
   .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
   .RVALID(RVALID), .RREADY(RREADY), .FRAME_PULSE_IN(FRAME_PULSE_IN), .IN_FRAME(IN_FRAME),
   .SAMPLED_IN_LINES(SAMPLED_IN_LINES), .OUT_FRAME(OUT_FRAME), .BLOCKING(BLOCKING),
   .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .CONST_DELAY_OK(CONST_DELAY_OK),
   .NIBBLE_MODE(NIBBLE_MODE), .FAST_CLOCK(FAST_CLOCK));

// [verification/tcs_switch_cfg_tb_top.sv]
`timescale 1ns/100ps
// register-level bench of the switch configuration block
module tcs_switch_cfg_tb_top;
   logic CLOCK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, hold_high;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FRAME_PULSE_IN, IN_FRAME, OUT_FRAME;
   logic BLOCKING, CONST_DELAY_OK, NIBBLE_MODE, FAST_CLOCK;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, rd, ex;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP, rr;
   logic [15:0] SERIAL_IN_LINES, SAMPLED_IN_LINES;
   logic [9:0] SERIAL_OUT_OE_N;
   int n_fail = 0;
   int n_tests = 0;
   logic ce = 1'h1;
   // mode byte, output enables, input mask, flags {err,offs,fast,nib,cd,blk}, channels
   logic [7:0] t_md [12] = '{8'h00, 8'ha0, 8'h20, 8'h40, 8'h60, 8'h02, 8'h42, 8'h6c,
      8'h69, 8'h71, 8'h63, 8'h65};
   logic [9:0] t_oe [12] = '{10'h300, 10'h300, 10'h3ff, 10'h1f8, 10'h3f0, 10'h3f0, 10'h3f0,
      10'h3fc, 10'h3f0, 10'h3fc, 10'h300, 10'h300};
   logic [15:0] t_in [12] = '{16'h00ff, 16'hffff, 16'h0000, 16'h0207, 16'h00ff, 16'h00ff,
      16'h000f, 16'h0003, 16'h00ff, 16'h00ff, 16'h000f, 16'h0003};
   logic [5:0] t_fl [12] = '{6'h02, 6'h01, 6'h21, 6'h02, 6'h05, 6'h11, 6'h12, 6'h1a, 6'h02,
      6'h0a, 6'h12, 6'h1a};
   logic [7:0] t_ch [12] = '{8'h20, 8'h20, 8'h00, 8'h20, 8'h40, 8'h40, 8'h40, 8'h80, 8'h00,
      8'h00, 8'h00, 8'h00};
   // offset setting, mode byte, expected frame distance
   logic [3:0] o_set [8] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf, 4'h3, 4'hb};
   logic [7:0] o_md [8] = '{8'h42, 8'h42, 8'h42, 8'h42, 8'h42, 8'h6c, 8'h42, 8'h00};
   logic [31:0] o_ex [8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h4, 32'h0, 32'h0};

   tcs_switch_cfg dut_u (.CLOCK(CLOCK), .ARST_N(ARST_N), .CE(ce), .AWADDR(AWADDR),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
      .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
      .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .FRAME_PULSE_IN(FRAME_PULSE_IN), .SERIAL_IN_LINES(SERIAL_IN_LINES),
      .SAMPLED_IN_LINES(SAMPLED_IN_LINES), .IN_FRAME(IN_FRAME), .OUT_FRAME(OUT_FRAME),
      .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .BLOCKING(BLOCKING), .CONST_DELAY_OK(CONST_DELAY_OK),
      .NIBBLE_MODE(NIBBLE_MODE), .FAST_CLOCK(FAST_CLOCK));
   tcs_backplane_model bp_u (.clk(CLOCK), .hold_high(hold_high), .frame_pulse(FRAME_PULSE_IN),
      .lines(SERIAL_IN_LINES));

   // 20 MHz clock
   initial begin
      CLOCK = 1'h0;
      forever #25 CLOCK = ~CLOCK;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // write: both channels offered together, response taken once seen
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge CLOCK);
      {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'h7};
      for (i = 0; i < 100; i++) begin
         @(posedge CLOCK);
         if (AWVALID && AWREADY === 1'h1) AWVALID <= 1'h0;
         if (WVALID && WREADY === 1'h1) WVALID <= 1'h0;
         if (BVALID === 1'h1) break;
      end
      r = BRESP;
      BREADY <= 1'h0;
      if (i == 100) begin
         n_fail++;
         report_and_stop();
      end
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge CLOCK);
      {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
      for (i = 0; i < 100; i++) begin
         @(posedge CLOCK);
         if (ARVALID && ARREADY === 1'h1) ARVALID <= 1'h0;
         if (RVALID === 1'h1) break;
      end
      {d, r} = {RDATA, RRESP};
      RREADY <= 1'h0;
      if (i == 100) begin
         n_fail++;
         report_and_stop();
      end
   endtask

   // cycles from output frame start to virtual input frame start
   task automatic gap(output logic [31:0] n);
      int i;
      n = 32'h0;
      for (i = 0; i < 100; i++) begin
         @(negedge CLOCK);
         if (OUT_FRAME === 1'h1) break;
      end
      while (IN_FRAME !== 1'h1 && n < 32'h8) begin
         n++;
         @(negedge CLOCK);
      end
      if (i == 100) begin
         n_fail++;
         report_and_stop();
      end
   endtask

   // main sequence
   initial begin
      {ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, hold_high} = 7'h00;
      {AWADDR, ARADDR, WDATA, WSTRB} = {48'h0, 4'hf};
      repeat (12) @(posedge CLOCK);
      ARST_N <= 1'h1;
      repeat (4) @(posedge CLOCK);
      axr(tcs_pkg::MODE_OFS, rd, rr);
      chk("mode", rd, {24'h0, tcs_pkg::MODE_RESET});
      axw(tcs_pkg::OFFSET_OFS, 32'h0, rr);
      axr(8'h10, rd, rr);
      chk("unmapped", {rd[29:0], rr}, {30'h0, tcs_pkg::AXI_SLVERR});
      axw(tcs_pkg::STATUS_OFS, 32'hff, rr);
      chk("status wr", {30'h0, rr}, {30'h0, tcs_pkg::AXI_SLVERR});
      axw(tcs_pkg::PAIR_OFS, 32'h92, rr);
      axr(tcs_pkg::PAIR_OFS, rd, rr);
      chk("pair", rd, 32'h92);
      hold_high <= 1'h1;
      for (int k = 0; k < 12; k++) begin
         axw(tcs_pkg::MODE_OFS, {24'h0, t_md[k]}, rr);
         repeat (8) @(posedge CLOCK);
         #1;
         chk("oe", {22'h0, SERIAL_OUT_OE_N}, {22'h0, t_oe[k]});
         chk("in", {16'h0, SAMPLED_IN_LINES}, {16'h0, t_in[k]});
         rd = {28'h0, FAST_CLOCK, NIBBLE_MODE, CONST_DELAY_OK, BLOCKING};
         chk("pins", rd, {28'h0, t_fl[k][3:0]});
         axr(tcs_pkg::STATUS_OFS, rd, rr);
         ex = {t_ch[k], 2'h0, ~t_oe[k], 6'h0, t_fl[k]};
         if (t_fl[k][5])
            chk("err", {31'h0, rd[5]}, 32'h1);
         else
            chk("status", rd, ex);
      end
      hold_high <= 1'h0;
      for (int k = 0; k < 8; k++) begin
         axw(tcs_pkg::MODE_OFS, {24'h0, o_md[k]}, rr);
         axw(tcs_pkg::OFFSET_OFS, {28'h0, o_set[k]}, rr);
         gap(rd);
         chk("offset", rd, o_ex[k]);
      end
      // enable low: the pulse inside this window must not reach the frame output
      @(posedge CLOCK);
      ce <= 1'h0;
      rd = 32'h0;
      repeat (45) begin
         @(negedge CLOCK);
         rd = rd + {31'h0, OUT_FRAME};
      end
      @(posedge CLOCK);
      ce <= 1'h1;
      chk("frozen", rd, 32'h0);
      report_and_stop();
   end
endmodule
